// File: rtl/clp_pkg.sv
/*
 * Shared constants for the user_enable_a-area and register-write command block:
 * command codes, parameter counts, register offsets, status bit positions,
 * reset values and the interpreter states.
 * Assumes 16-bit display-list words with the command code in bits 15:11.
 */
package clp_pkg;

  // Command word layout
  localparam int unsigned CODE_MSB = 15;
  localparam int unsigned CODE_LSB = 11;
  localparam int unsigned MODE_MSB = 10;

  // Command codes
  localparam logic [4:0] CODE_SYS_USER_ENABLE_A  = 5'h17;
  localparam logic [4:0] CODE_USER_USER_ENABLE_A = 5'h15;
  localparam logic [4:0] CODE_REG_WRITE = 5'h16;

  // Parameter words that follow each command word
  localparam logic [2:0] NPAR_SYS  = 3'h2;
  localparam logic [2:0] NPAR_USER = 3'h4;
  localparam logic [2:0] NPAR_REG  = 3'h2;

  // Wishbone register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_SYS    = 8'h08;
  localparam logic [7:0] ADR_ULO    = 8'h0c;
  localparam logic [7:0] ADR_UHI    = 8'h10;
  localparam logic [7:0] ADR_WPR    = 8'h14;

  // Control bits
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam logic        CTRL_RUN_RST = 1'h1;

  // Status bits
  localparam int unsigned ST_SYS_VALID  = 0;
  localparam int unsigned ST_USR_VALID  = 1;
  localparam int unsigned ST_ERR_MODE   = 2;
  localparam int unsigned ST_ERR_TARGET = 3;
  localparam int unsigned ST_ERR_CODE   = 4;
  localparam int unsigned ST_BUSY       = 5;
  localparam int unsigned ST_RUN        = 6;

  // Reset value of user_enable_a bounds and parameter words
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Registers that the register-write command may target
  localparam logic [15:0] RN_DISP_A0  = 16'h000a;
  localparam logic [15:0] RN_DISP_A1  = 16'h000b;
  localparam logic [15:0] RN_SRC_SA   = 16'h000e;
  localparam logic [15:0] RN_WORK_SA  = 16'h000f;
  localparam logic [15:0] RN_DRAW_SA  = 16'h004c;
  localparam logic [15:0] RN_BITMODE  = 16'h0006;
  localparam logic [15:0] RN_RET_HI   = 16'h004a;
  localparam logic [15:0] RN_RET_LO   = 16'h004b;
  localparam logic [15:0] RN_COLOR_OF = 16'h004d;

  // Interpreter states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_PARAM = 2'b10
  } clp_state_t;

endpackage : clp_pkg

// File: rtl/clp_cmd_decode.sv
/*
 * Combinational decode of a display-list command word: recognises the
 * three user_enable_a and register-write codes, gives the parameter count and
 * flags mode bits that should be zero.
 * Assumes the word is stable while it is offered.
 */
`timescale 1ns/10ps
module clp_cmd_decode (
  input  wire logic [15:0] i_word,
  output logic             o_known,
  output logic [2:0]       o_npar,
  output logic             o_mode_bad
);

  logic [4:0] code;

  // Code lookup and zero-mode check
  always_comb begin
    code       = i_word[clp_pkg::CODE_MSB:clp_pkg::CODE_LSB];
    o_mode_bad = |i_word[clp_pkg::MODE_MSB:0];
    o_known    = 1'b1;
    o_npar     = clp_pkg::NPAR_SYS;
    case (code)
      clp_pkg::CODE_SYS_USER_ENABLE_A:  o_npar = clp_pkg::NPAR_SYS;
      clp_pkg::CODE_USER_USER_ENABLE_A: o_npar = clp_pkg::NPAR_USER;
      clp_pkg::CODE_REG_WRITE: o_npar = clp_pkg::NPAR_REG;
      default:                 o_known = 1'b0;
    endcase
  end

endmodule : clp_cmd_decode

// File: rtl/clp_pix_user_enable_a.sv
/*
 * Pixel write gate: passes a drawing pixel only when it lies inside the
 * system user_enable_a rectangle and, when user clipping is on, the user one.
 * Assumes pixel requests come from drawing logic on the same clock.
 */
`timescale 1ns/10ps
module clp_pix_user_enable_a (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_pix_valid,
  input  wire logic [15:0] i_pix_x,
  input  wire logic [15:0] i_pix_y,
  input  wire logic        i_user_enable_a,
  input  wire logic        i_sys_valid,
  input  wire logic [15:0] i_sys_x_upper,
  input  wire logic [15:0] i_sys_y_upper,
  input  wire logic [15:0] i_usr_x_lower,
  input  wire logic [15:0] i_usr_y_lower,
  input  wire logic [15:0] i_usr_x_upper,
  input  wire logic [15:0] i_usr_y_upper,
  output logic             o_pix_write,
  output logic [15:0]      o_pix_x,
  output logic [15:0]      o_pix_y
);

  logic        in_sys;
  logic        in_usr;
  logic        write_nxt;
  logic        write_r;
  logic [15:0] x_r;
  logic [15:0] y_r;

  // Signed compares: corner (0,0) is fixed for the system rectangle
  always_comb begin
    in_sys = i_sys_valid
           && ($signed(i_pix_x) >= 0) && ($signed(i_pix_y) >= 0)
           && ($signed(i_pix_x) <= $signed(i_sys_x_upper))
           && ($signed(i_pix_y) <= $signed(i_sys_y_upper));
    in_usr = ($signed(i_pix_x) >= $signed(i_usr_x_lower))
           && ($signed(i_pix_y) >= $signed(i_usr_y_lower))
           && ($signed(i_pix_x) <= $signed(i_usr_x_upper))
           && ($signed(i_pix_y) <= $signed(i_usr_y_upper));
    write_nxt = i_pix_valid && in_sys
              && (!i_user_enable_a || in_usr);
  end

  // Output register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      write_r <= 1'b0;
      x_r     <= clp_pkg::WORD_RST;
      y_r     <= clp_pkg::WORD_RST;
    end else begin
      write_r <= write_nxt;
      x_r     <= i_pix_x;
      y_r     <= i_pix_y;
    end
  end

  assign o_pix_write = write_r;
  assign o_pix_x     = x_r;
  assign o_pix_y     = y_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sys_outside_a: assert property (i_pix_valid && (($signed(i_pix_x) >
      $signed(i_sys_x_upper)) || !i_sys_valid) |=> !o_pix_write)
    else $error("pixel outside system user_enable_a was written");
  user_gate_a: assert property (i_pix_valid && in_sys && !i_user_enable_a
      |=> o_pix_write)
    else $error("user user_enable_a applied while disabled");
  user_user_enable_a_a: assert property (i_pix_valid && i_user_enable_a && !in_usr
      |=> !o_pix_write)
    else $error("pixel outside user user_enable_a was written");
  pix_clipped_c: cover property (i_pix_valid && i_user_enable_a && !in_usr);

endmodule : clp_pix_user_enable_a

// File: rtl/clp_cmd_top.sv
/*
 * Command interpreter for the system user_enable_a, user user_enable_a and register-write
 * display-list commands, with a classic Wishbone slave for control and
 * status, and a pixel gate that clips drawing writes to the rectangles.
 * Assumes command words and pixel requests come from logic on the same
 * clock, and a classic single-cycle Wishbone master.
 */
//
// Function
// - Code 10111 starts a system user_enable_a command with two bound words.
// - The system rectangle runs from (0,0) to the given upper X and Y.
// - User_enable_a bounds are stored as given, with no local offset added.
// - Code 10101 starts a user user_enable_a command with four bound words.
// - The user rectangle runs from the lower X,Y to the upper X,Y.
// - The user rectangle clips only while the user enable bit is 1.
// - Code 10110 starts a register-write command: number, then data.
// - Only the permitted register numbers may be written by command.
`timescale 1ns/10ps
module clp_cmd_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_cmd_valid,
  input  wire logic [15:0] i_cmd_word,
  output logic             o_cmd_ready,
  output logic             o_reg_wr_stb,
  output logic [15:0]      o_reg_wr_num,
  output logic [15:0]      o_reg_wr_data,
  input  wire logic        i_pix_valid,
  input  wire logic [15:0] i_pix_x,
  input  wire logic [15:0] i_pix_y,
  input  wire logic        i_user_enable_a,
  output logic             o_pix_write,
  output logic [15:0]      o_pix_x,
  output logic [15:0]      o_pix_y
);

  clp_pkg::clp_state_t state_r, state_nxt;
  logic [4:0]  code_r, code_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [1:0]  idx_r, idx_nxt;
  logic [15:0] par_r [4];
  logic [15:0] par_nxt [4];
  logic [15:0] p [4];
  logic [15:0] sys_x_r, sys_x_nxt, sys_y_r, sys_y_nxt;
  logic [15:0] ulx_r, ulx_nxt, uly_r, uly_nxt;
  logic [15:0] uux_r, uux_nxt, uuy_r, uuy_nxt;
  logic        sys_valid_r, sys_valid_nxt, usr_valid_r, usr_valid_nxt;
  logic        err_mode_r, err_mode_nxt, err_tgt_r, err_tgt_nxt;
  logic        err_code_r, err_code_nxt;
  logic        wr_stb_r, wr_stb_nxt;
  logic [15:0] wr_num_r, wr_num_nxt, wr_data_r, wr_data_nxt;
  logic        run_r, run_nxt, ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        known, mode_bad, take, commit, allowed, ctrl_wr, clr_err;
  logic [2:0]  npar;

  clp_cmd_decode u_decode (
    .i_word     (i_cmd_word),
    .o_known    (known),
    .o_npar     (npar),
    .o_mode_bad (mode_bad)
  );

  // Handshake, last-word detect and permitted-target check
  assign take    = i_cmd_valid && run_r;
  assign commit  = take && (state_r == clp_pkg::ST_PARAM)
                 && (cnt_r == 3'h1);
  assign allowed = (p[0] == clp_pkg::RN_DISP_A0)
                || (p[0] == clp_pkg::RN_DISP_A1)
                || (p[0] == clp_pkg::RN_SRC_SA)
                || (p[0] == clp_pkg::RN_WORK_SA)
                || (p[0] == clp_pkg::RN_DRAW_SA)
                || (p[0] == clp_pkg::RN_BITMODE)
                || (p[0] == clp_pkg::RN_RET_HI)
                || (p[0] == clp_pkg::RN_RET_LO)
                || (p[0] == clp_pkg::RN_COLOR_OF);
  assign ctrl_wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r
                && (i_wb_adr == clp_pkg::ADR_CTRL) && i_wb_sel[0];
  assign clr_err = ctrl_wr && i_wb_dat[clp_pkg::CTRL_CLR_BIT];

  // Interpreter next state: collect parameters, commit on the last word
  always_comb begin
    state_nxt = state_r;
    code_nxt  = code_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    for (int k = 0; k < 4; k++) begin
      p[k]       = par_r[k];
      par_nxt[k] = par_r[k];
    end
    p[idx_r]      = i_cmd_word;
    sys_x_nxt     = sys_x_r;
    sys_y_nxt     = sys_y_r;
    ulx_nxt       = ulx_r;
    uly_nxt       = uly_r;
    uux_nxt       = uux_r;
    uuy_nxt       = uuy_r;
    sys_valid_nxt = sys_valid_r;
    usr_valid_nxt = usr_valid_r;
    wr_stb_nxt    = 1'b0;
    wr_num_nxt    = wr_num_r;
    wr_data_nxt   = wr_data_r;
    // Software clear first, so a same-cycle event still sets the flag
    err_mode_nxt  = err_mode_r && !clr_err;
    err_tgt_nxt   = err_tgt_r && !clr_err;
    err_code_nxt  = err_code_r && !clr_err;
    if (take) begin
      case (state_r)
        clp_pkg::ST_IDLE: begin
          if (known) begin
            code_nxt  = i_cmd_word[clp_pkg::CODE_MSB:clp_pkg::CODE_LSB];
            cnt_nxt   = npar;
            idx_nxt   = 2'h0;
            state_nxt = clp_pkg::ST_PARAM;
            if (mode_bad) begin
              err_mode_nxt = 1'b1;
            end
          end else begin
            err_code_nxt = 1'b1;
          end
        end
        clp_pkg::ST_PARAM: begin
          par_nxt[idx_r] = i_cmd_word;
          idx_nxt        = idx_r + 2'h1;
          cnt_nxt        = cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            state_nxt = clp_pkg::ST_IDLE;
            if (code_r == clp_pkg::CODE_SYS_USER_ENABLE_A) begin
              sys_x_nxt     = p[0];
              sys_y_nxt     = p[1];
              sys_valid_nxt = 1'b1;
            end else if (code_r == clp_pkg::CODE_USER_USER_ENABLE_A) begin
              ulx_nxt       = p[0];
              uly_nxt       = p[1];
              uux_nxt       = p[2];
              uuy_nxt       = p[3];
              usr_valid_nxt = 1'b1;
            end else if (allowed) begin
              wr_stb_nxt  = 1'b1;
              wr_num_nxt  = p[0];
              wr_data_nxt = p[1];
            end else begin
              err_tgt_nxt = 1'b1;
            end
          end
        end
        default: state_nxt = clp_pkg::ST_IDLE;
      endcase
    end
  end

  // Interpreter registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_r     <= clp_pkg::ST_IDLE;
      code_r      <= 5'h00;
      cnt_r       <= 3'h0;
      idx_r       <= 2'h0;
      for (int k = 0; k < 4; k++) begin
        par_r[k] <= clp_pkg::WORD_RST;
      end
      sys_x_r     <= clp_pkg::WORD_RST;
      sys_y_r     <= clp_pkg::WORD_RST;
      ulx_r       <= clp_pkg::WORD_RST;
      uly_r       <= clp_pkg::WORD_RST;
      uux_r       <= clp_pkg::WORD_RST;
      uuy_r       <= clp_pkg::WORD_RST;
      sys_valid_r <= 1'b0;
      usr_valid_r <= 1'b0;
      err_mode_r  <= 1'b0;
      err_tgt_r   <= 1'b0;
      err_code_r  <= 1'b0;
      wr_stb_r    <= 1'b0;
      wr_num_r    <= clp_pkg::WORD_RST;
      wr_data_r   <= clp_pkg::WORD_RST;
    end else begin
      state_r     <= state_nxt;
      code_r      <= code_nxt;
      cnt_r       <= cnt_nxt;
      idx_r       <= idx_nxt;
      par_r       <= par_nxt;
      sys_x_r     <= sys_x_nxt;
      sys_y_r     <= sys_y_nxt;
      ulx_r       <= ulx_nxt;
      uly_r       <= uly_nxt;
      uux_r       <= uux_nxt;
      uuy_r       <= uuy_nxt;
      sys_valid_r <= sys_valid_nxt;
      usr_valid_r <= usr_valid_nxt;
      err_mode_r  <= err_mode_nxt;
      err_tgt_r   <= err_tgt_nxt;
      err_code_r  <= err_code_nxt;
      wr_stb_r    <= wr_stb_nxt;
      wr_num_r    <= wr_num_nxt;
      wr_data_r   <= wr_data_nxt;
    end
  end

  // Wishbone slave: ack one cycle after the request, read data with it
  always_comb begin
    ack_nxt  = i_wb_cyc && i_wb_stb && !ack_r;
    run_nxt  = run_r;
    rdat_nxt = 32'h0000_0000;
    if (ctrl_wr) begin
      run_nxt = i_wb_dat[clp_pkg::CTRL_RUN_BIT];
    end
    if (i_wb_adr == clp_pkg::ADR_CTRL) begin
      rdat_nxt[clp_pkg::CTRL_RUN_BIT] = run_r;
    end else if (i_wb_adr == clp_pkg::ADR_STATUS) begin
      rdat_nxt[clp_pkg::ST_SYS_VALID]  = sys_valid_r;
      rdat_nxt[clp_pkg::ST_USR_VALID]  = usr_valid_r;
      rdat_nxt[clp_pkg::ST_ERR_MODE]   = err_mode_r;
      rdat_nxt[clp_pkg::ST_ERR_TARGET] = err_tgt_r;
      rdat_nxt[clp_pkg::ST_ERR_CODE]   = err_code_r;
      rdat_nxt[clp_pkg::ST_BUSY]       = state_r == clp_pkg::ST_PARAM;
      rdat_nxt[clp_pkg::ST_RUN]        = run_r;
    end else if (i_wb_adr == clp_pkg::ADR_SYS) begin
      rdat_nxt = {sys_y_r, sys_x_r};
    end else if (i_wb_adr == clp_pkg::ADR_ULO) begin
      rdat_nxt = {uly_r, ulx_r};
    end else if (i_wb_adr == clp_pkg::ADR_UHI) begin
      rdat_nxt = {uuy_r, uux_r};
    end else if (i_wb_adr == clp_pkg::ADR_WPR) begin
      rdat_nxt = {wr_data_r, wr_num_r};
    end
  end

  // Bus registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      ack_r  <= 1'b0;
      run_r  <= clp_pkg::CTRL_RUN_RST;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= ack_nxt;
      run_r  <= run_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  clp_pix_user_enable_a u_user_enable_a (
    .i_core_clk      (i_core_clk),
    .i_rst_b         (i_rst_b),
    .i_pix_valid     (i_pix_valid),
    .i_pix_x         (i_pix_x),
    .i_pix_y         (i_pix_y),
    .i_user_enable_a (i_user_enable_a),
    .i_sys_valid     (sys_valid_r),
    .i_sys_x_upper   (sys_x_r),
    .i_sys_y_upper   (sys_y_r),
    .i_usr_x_lower   (ulx_r),
    .i_usr_y_lower   (uly_r),
    .i_usr_x_upper   (uux_r),
    .i_usr_y_upper   (uuy_r),
    .o_pix_write     (o_pix_write),
    .o_pix_x         (o_pix_x),
    .o_pix_y         (o_pix_y)
  );

  assign o_wb_ack      = ack_r;
  assign o_wb_dat      = rdat_r;
  assign o_cmd_ready   = run_r;
  assign o_reg_wr_stb  = wr_stb_r;
  assign o_reg_wr_num  = wr_num_r;
  assign o_reg_wr_data = wr_data_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sys_decode_a: assert property (take && state_r == clp_pkg::ST_IDLE
      && i_cmd_word[15:11] == clp_pkg::CODE_SYS_USER_ENABLE_A
      |=> state_r == clp_pkg::ST_PARAM && cnt_r == 3'h2)
    else $error("system user_enable_a code not decoded");
  sys_load_a: assert property (commit && code_r == clp_pkg::CODE_SYS_USER_ENABLE_A
      |=> sys_x_r == $past(par_r[0]) && sys_y_r == $past(i_cmd_word)
      && sys_valid_r)
    else $error("system user_enable_a bounds not stored as given");
  user_decode_a: assert property (take && state_r == clp_pkg::ST_IDLE
      && i_cmd_word[15:11] == clp_pkg::CODE_USER_USER_ENABLE_A
      |=> state_r == clp_pkg::ST_PARAM && cnt_r == 3'h4)
    else $error("user user_enable_a code not decoded");
  user_load_a: assert property (commit && code_r == clp_pkg::CODE_USER_USER_ENABLE_A
      |=> ulx_r == $past(par_r[0]) && uly_r == $past(par_r[1])
      && uux_r == $past(par_r[2]) && uuy_r == $past(i_cmd_word))
    else $error("user user_enable_a bounds not stored as given");
  reg_decode_a: assert property (take && state_r == clp_pkg::ST_IDLE
      && i_cmd_word[15:11] == clp_pkg::CODE_REG_WRITE
      ##1 take [*2] |=> o_reg_wr_stb || err_tgt_r)
    else $error("register write command had no effect");
  reg_forward_a: assert property (commit && allowed
      && code_r == clp_pkg::CODE_REG_WRITE |=> o_reg_wr_stb
      && o_reg_wr_data == $past(i_cmd_word) ##1 !o_reg_wr_stb)
    else $error("permitted register write not forwarded once");
  reg_block_a: assert property (commit && !allowed
      && code_r == clp_pkg::CODE_REG_WRITE
      |=> !o_reg_wr_stb && err_tgt_r)
    else $error("forbidden register write was forwarded");
  mode_flag_a: assert property (take && state_r == clp_pkg::ST_IDLE
      && known && mode_bad |=> err_mode_r)
    else $error("nonzero mode bits not flagged");
  sys_cmd_c: cover property (commit && code_r == clp_pkg::CODE_SYS_USER_ENABLE_A);
  user_cmd_c: cover property (commit && code_r == clp_pkg::CODE_USER_USER_ENABLE_A);
  reg_cmd_c: cover property (o_reg_wr_stb);

endmodule : clp_cmd_top

// File: verif/clp_list_src.sv
/*
 * List source model: hands display-list words to the command port,
 * one word at a time, holding each until the block takes it.
 * Assumes the bench pushes whole commands and may set slow pacing.
 */
`timescale 1ns/10ps
module clp_list_src (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [15:0]      o_word
);
  logic [15:0] q_words[$];
  logic        slow = 1'b0;

  // Words are queued as given, mode bits included
  task automatic push(input logic [15:0] w);
    q_words.push_back(w);
  endtask : push

  // Holds a word until taken; idle line toggles so stale data shows
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
      o_word  <= 16'h0000;
    end else begin
      if (o_valid && i_ready) begin
        void'(q_words.pop_front());
      end
      if (q_words.size() != 0 && !(slow && o_valid && i_ready)) begin
        o_valid <= 1'b1;
        o_word  <= q_words[0];
      end else begin
        o_valid <= 1'b0;
        o_word  <= ~o_word;
      end
    end
  end
endmodule : clp_list_src

// File: verif/test_user_enable_a_area_and_reg_write_cmds.sv
/*
 * Self-checking bench: register bus, user_enable_a commands, register writes
 * and pixel gating. Assumes clp_list_src feeds the command port.
 */
`timescale 1ns/10ps
module test_user_enable_a_area_and_reg_write_cmds;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic        en;
    logic        ok;
  } clp_row_t;

  logic        i_core_clk = 1'b0;
  logic        i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we, i_pix_valid;
  logic        i_user_enable_a, o_wb_ack, cmd_valid, o_cmd_ready;
  logic        o_reg_wr_stb, o_pix_write;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic [15:0] cmd_word, o_reg_wr_num, o_reg_wr_data;
  logic [15:0] i_pix_x, i_pix_y, o_pix_x, o_pix_y;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc_count = 0;
  // Inside/outside points against system (19,15) and user (4,2)-(11,9)
  clp_row_t    rows [0:10] = '{
    '{16'h0000, 16'h0000, 1'b0, 1'b1}, '{16'h0013, 16'h000f, 1'b0, 1'b1},
    '{16'h0014, 16'h0000, 1'b0, 1'b0}, '{16'h0000, 16'h0010, 1'b0, 1'b0},
    '{16'hffff, 16'h0000, 1'b0, 1'b0}, '{16'h0003, 16'h0005, 1'b1, 1'b0},
    '{16'h0004, 16'h0002, 1'b1, 1'b1}, '{16'h000b, 16'h0009, 1'b1, 1'b1},
    '{16'h000c, 16'h0009, 1'b1, 1'b0}, '{16'h000b, 16'h000a, 1'b1, 1'b0},
    '{16'h0003, 16'h0005, 1'b0, 1'b1}};
  logic [15:0] rn_ok [0:8] = '{clp_pkg::RN_DISP_A0, clp_pkg::RN_DISP_A1,
    clp_pkg::RN_SRC_SA, clp_pkg::RN_WORK_SA, clp_pkg::RN_DRAW_SA,
    clp_pkg::RN_BITMODE, clp_pkg::RN_RET_HI, clp_pkg::RN_RET_LO,
    clp_pkg::RN_COLOR_OF};

  clp_cmd_top DUT (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_cmd_valid(cmd_valid), .i_cmd_word(cmd_word),
    .o_cmd_ready(o_cmd_ready), .o_reg_wr_stb(o_reg_wr_stb),
    .o_reg_wr_num(o_reg_wr_num), .o_reg_wr_data(o_reg_wr_data),
    .i_pix_valid(i_pix_valid), .i_pix_x(i_pix_x), .i_pix_y(i_pix_y),
    .i_user_enable_a(i_user_enable_a), .o_pix_write(o_pix_write),
    .o_pix_x(o_pix_x), .o_pix_y(o_pix_y));

  clp_list_src u_src (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ready(o_cmd_ready),
    .o_valid(cmd_valid), .o_word(cmd_word));

  // Clock and hang guard
  always #10 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Classic single cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
    i_wb_sel <= 4'hf;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    rd = o_wb_dat;
    if (n >= 50) err_total++;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rd_chk

  // Waits until the list source has handed over every word
  task automatic flush();
    int n;
    n = 0;
    while (u_src.q_words.size() != 0 && n < 50) begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 50) err_total++;
    repeat (2) @(posedge i_core_clk);
  endtask : flush

  task automatic cmd3(input logic [15:0] w0, w1, w2);
    u_src.push(w0);
    u_src.push(w1);
    u_src.push(w2);
  endtask : cmd3

  task automatic reg_wr(input logic [15:0] num, dat, input int exp_n);
    int n;
    n = 0;
    cmd3({clp_pkg::CODE_REG_WRITE, 11'h000}, num, dat);
    repeat (20) begin
      @(posedge i_core_clk);
      #1;
      if (o_reg_wr_stb === 1'b1) begin
        n++;
        check({o_reg_wr_num, o_reg_wr_data}, {num, dat});
      end
    end
    check(n, exp_n);
  endtask : reg_wr

  task automatic pix(input clp_row_t r);
    @(posedge i_core_clk);
    {i_pix_valid, i_user_enable_a} <= {1'b1, r.en};
    {i_pix_x, i_pix_y} <= {r.x, r.y};
    @(posedge i_core_clk);
    i_pix_valid <= 1'b0;
    #1;
    check({o_pix_write, o_pix_x, o_pix_y}, {r.ok, r.x, r.y});
  endtask : pix

  initial begin
    {i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we, i_pix_valid} = 5'h00;
    {i_user_enable_a, i_wb_adr, i_wb_sel, i_wb_dat} = {1'b0, 8'h00, 4'hf,
                                                       32'h0};
    {i_pix_x, i_pix_y} = 32'h0;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    // Reset state, unmapped read, pixels held off before any user_enable_a set
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_0040);
    rd_chk(clp_pkg::ADR_SYS, 32'h0);
    rd_chk(8'h20, 32'h0);
    pix('{16'h0000, 16'h0000, 1'b0, 1'b0});
    // First list opens with system bounds, upper X = 19, upper Y = 15
    cmd3({clp_pkg::CODE_SYS_USER_ENABLE_A, 11'h000}, 16'h0013, 16'h000f);
    // User bounds inside system, lower X 4, upper X 11
    u_src.slow = 1'b1;
    cmd3({clp_pkg::CODE_USER_USER_ENABLE_A, 11'h000}, 16'h0004, 16'h0002);
    u_src.push(16'h000b);
    u_src.push(16'h0009);
    flush();
    u_src.slow = 1'b0;
    rd_chk(clp_pkg::ADR_SYS, 32'h000f_0013);
    rd_chk(clp_pkg::ADR_ULO, 32'h0002_0004);
    rd_chk(clp_pkg::ADR_UHI, 32'h0009_000b);
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_0043);
    foreach (rows[i]) pix(rows[i]);
    foreach (rn_ok[i]) reg_wr(rn_ok[i], rn_ok[i] ^ 16'h5a5a, 1);
    reg_wr(16'h0007, 16'h1234, 0);
    rd_chk(clp_pkg::ADR_WPR, 32'h5a17_004d);
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_004b);
    // Nonzero mode bits flag but the command still runs
    cmd3({clp_pkg::CODE_SYS_USER_ENABLE_A, 11'h001}, 16'h0005, 16'h0005);
    u_src.push(16'hf800);
    flush();
    rd_chk(clp_pkg::ADR_SYS, 32'h0005_0005);
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_005f);
    wb(1'b1, clp_pkg::ADR_CTRL, 32'h3);
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_0043);
    rd_chk(clp_pkg::ADR_CTRL, 32'h0000_0001);
    // Half-done command shows busy; stopped, it takes no further words
    u_src.push({clp_pkg::CODE_SYS_USER_ENABLE_A, 11'h000});
    u_src.push(16'h0010);
    flush();
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_0063);
    wb(1'b1, clp_pkg::ADR_CTRL, 32'h0);
    u_src.push(16'h0010);
    repeat (3) @(posedge i_core_clk);
    rd_chk(clp_pkg::ADR_SYS, 32'h0005_0005);
    rd_chk(clp_pkg::ADR_STATUS, 32'h0000_0023);
    check({31'h0, o_cmd_ready}, 32'h0);
    wb(1'b1, clp_pkg::ADR_CTRL, 32'h1);
    flush();
    rd_chk(clp_pkg::ADR_SYS, 32'h0010_0010);
    stop_test();
  end
endmodule : test_user_enable_a_area_and_reg_write_cmds
